/* File: pdm_pkg.sv */
// Package for the pulse density modulator: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus; one register per aligned word.
package pdm_pkg;

    // ------------------------------------------------------------------
    // Register indices (printed offsets) and bus address width
    // ------------------------------------------------------------------
    localparam logic [7:0] PDM_IDX_PORT2_SEL  = 8'h27;
    localparam logic [7:0] PDM_IDX_DW1_HIGH   = 8'h30;
    localparam logic [7:0] PDM_IDX_DW1_LOW    = 8'h31;
    localparam logic [7:0] PDM_IDX_DW2_HIGH   = 8'h32;
    localparam logic [7:0] PDM_IDX_DW2_LOW    = 8'h33;
    localparam logic [7:0] PDM_IDX_CONTROL    = 8'h36;
    localparam int         PDM_ADDR_W         = 10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PDM_BIT_PIN2_SEL   = 4;
    localparam int PDM_BIT_PIN5_SEL   = 6;
    localparam int PDM_BIT_ENABLE     = 4;
    localparam int PDM_DIV_SEL_MSB    = 2;

    // ------------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------------
    localparam logic [7:0] PDM_RST_BYTE   = 8'h00;
    localparam int         PDM_WORD_W     = 16;
    localparam int         PDM_PRESC_W    = 7;

    localparam logic [1:0] PDM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PDM_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       pin5_sel;
        logic       pin2_sel;
        logic       enable;
        logic [2:0] div_sel;
    } pdm_ctrl_t;

    typedef struct packed {
        logic pin2_out;
        logic pin5_out;
        logic pin2_oe_n;
        logic pin5_oe_n;
    } pdm_pins_t;

endpackage

/* File: pdm_divider.sv */
// Prescaler for the modulator clock: one-cycle enable pulse per period.
// Assumes the caller holds it cleared while the modulator is off.
`timescale 1ns/1ps
`default_nettype none
module pdm_divider #(
    parameter int PRESC_W = 7
) (
    input  wire logic               ref_clk_i,
    input  wire logic               reset_i,
    input  wire logic               run_i,
    input  wire logic [2:0]         div_sel_i,
    output logic                    tick_o
);
    import pdm_pkg::*;

    initial begin
        if (PRESC_W != 7) begin
            $error("pdm_divider: PRESC_W must be 7");
        end
    end

    logic [PRESC_W-1:0] cnt_ff;
    logic               tick_ff;
    wire  [PRESC_W-1:0] limit  = PRESC_W'((8'h01 << div_sel_i) - 8'h01);
    wire                at_end = (cnt_ff >= limit);

    // ------------------------------------------------------------------
    // Divide by 2**div_sel, 000 -> every cycle, 111 -> by 128
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !run_i) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= at_end ? '0 : cnt_ff + 1'b1;
            tick_ff <= at_end;
        end
    end

    assign tick_o = tick_ff;

    div_tick_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (run_i && $stable(div_sel_i) && cnt_ff == limit && limit != '0)
        |=> tick_o ##1 !tick_o)
        else $error("divider tick not single-cycle at terminal count");

endmodule
`default_nettype wire

/* File: pdm_top.sv */
// Pulse density modulator with AXI4-Lite register slave and two pin outputs.
// Assumes a single 250 MHz clock, synchronous active-high reset, and that
// software sets the GPIO direction outside this block.
//
// What this block does
// - The enable bit lets port 2 bit 2 carry the modulator; when clear the modulator idles.
// - The modulator clock is the master clock divided by 1 to 128, doubling per select step.
// - The modulator clock is split into sixteen component signals numbered 15 to 0.
// - Component 15 runs at half the modulator clock, each lower one at half the next.
// - The output combines exactly the components whose bits are set in the density word.
// - Any word 0 to 65535 is accepted and the duty cycle equals the word over 65536.
// - Density word one is read and written as a high byte at 0x30 and low byte at 0x31.
// - Density word two has the same mapping, high byte at 0x32 and low byte at 0x33.
// - Pin-select bit 4 of the port 2 mode register routes the modulator to port 2 bit 2.
// - Pin-select bit 6 of the port 2 mode register routes a modulator to port 2 bit 5.
// - The control register at 0x36 holds enable in bit 4, divider select in bits 2 to 0.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pdm_top #(
    parameter int WORD_W = 16
) (
    input  wire logic                          ref_clk_i,
    input  wire logic                          reset_i,
    input  wire logic [pdm_pkg::PDM_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                          s_axi_awvalid_i,
    output logic                               s_axi_awready_o,
    input  wire logic [31:0]                   s_axi_wdata_i,
    input  wire logic [3:0]                    s_axi_wstrb_i,
    input  wire logic                          s_axi_wvalid_i,
    output logic                               s_axi_wready_o,
    output logic [1:0]                         s_axi_bresp_o,
    output logic                               s_axi_bvalid_o,
    input  wire logic                          s_axi_bready_i,
    input  wire logic [pdm_pkg::PDM_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                          s_axi_arvalid_i,
    output logic                               s_axi_arready_o,
    output logic [31:0]                        s_axi_rdata_o,
    output logic [1:0]                         s_axi_rresp_o,
    output logic                               s_axi_rvalid_o,
    input  wire logic                          s_axi_rready_i,
    input  wire logic [7:0]                    port_two_gpio_out_i,
    input  wire logic [7:0]                    port_two_direction_i,
    output pdm_pkg::pdm_pins_t                 pins_o
);
    import pdm_pkg::*;

    initial begin
        if (WORD_W != PDM_WORD_W) begin
            $error("pdm_top: WORD_W must be 16");
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0]        dw1_hi_ff, dw1_lo_ff, dw2_hi_ff, dw2_lo_ff;
    pdm_ctrl_t         ctrl_ff;
    logic              aw_held_ff, w_held_ff;
    logic [7:0]        aw_idx_ff;
    logic [7:0]        wbyte_ff;
    logic              wstrb0_ff;
    logic              bvalid_ff, rvalid_ff, awrdy_ff, wrdy_ff, ardy_ff;
    logic [1:0]        bresp_ff, rresp_ff;
    logic [31:0]       rdata_ff;

    // ------------------------------------------------------------------
    // Write channel: address and data taken in either order
    // ------------------------------------------------------------------
    wire aw_take = s_axi_awvalid_i && !aw_held_ff && !bvalid_ff;
    wire w_take  = s_axi_wvalid_i && !w_held_ff && !bvalid_ff;
    wire aw_have = aw_held_ff || aw_take;
    wire w_have  = w_held_ff || w_take;
    wire wr_go   = aw_have && w_have && !bvalid_ff;
    wire [7:0] wr_idx  = aw_held_ff ? aw_idx_ff : s_axi_awaddr_i[9:2];
    wire [7:0] wr_byte = w_held_ff ? wbyte_ff : s_axi_wdata_i[7:0];
    wire       wr_lane = w_held_ff ? wstrb0_ff : s_axi_wstrb_i[0];
    wire       wr_en   = wr_go && wr_lane;
    wire nxt_aw_held = aw_have && !wr_go;
    wire nxt_w_held  = w_have && !wr_go;
    wire nxt_bvalid  = wr_go || (bvalid_ff && !s_axi_bready_i);

    wire hit_sel  = (wr_idx == PDM_IDX_PORT2_SEL);
    wire hit_d1h  = (wr_idx == PDM_IDX_DW1_HIGH);
    wire hit_d1l  = (wr_idx == PDM_IDX_DW1_LOW);
    wire hit_d2h  = (wr_idx == PDM_IDX_DW2_HIGH);
    wire hit_d2l  = (wr_idx == PDM_IDX_DW2_LOW);
    wire hit_ctl  = (wr_idx == PDM_IDX_CONTROL);
    wire wr_known = hit_sel | hit_d1h | hit_d1l | hit_d2h | hit_d2l | hit_ctl;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_idx_ff  <= 8'h00;
            wbyte_ff   <= 8'h00;
            wstrb0_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= PDM_RESP_OKAY;
            awrdy_ff   <= 1'b1;
            wrdy_ff    <= 1'b1;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            awrdy_ff   <= !nxt_aw_held && !nxt_bvalid;
            wrdy_ff    <= !nxt_w_held && !nxt_bvalid;
            if (aw_take) begin
                aw_idx_ff <= s_axi_awaddr_i[9:2];
            end
            if (w_take) begin
                wbyte_ff  <= s_axi_wdata_i[7:0];
                wstrb0_ff <= s_axi_wstrb_i[0];
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_known ? PDM_RESP_OKAY : PDM_RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            dw1_hi_ff <= PDM_RST_BYTE;
            dw1_lo_ff <= PDM_RST_BYTE;
            dw2_hi_ff <= PDM_RST_BYTE;
            dw2_lo_ff <= PDM_RST_BYTE;
            ctrl_ff   <= '0;
        end else if (wr_en) begin
            if (hit_d1h) dw1_hi_ff <= wr_byte;
            if (hit_d1l) dw1_lo_ff <= wr_byte;
            if (hit_d2h) dw2_hi_ff <= wr_byte;
            if (hit_d2l) dw2_lo_ff <= wr_byte;
            if (hit_sel) begin
                ctrl_ff.pin2_sel <= wr_byte[PDM_BIT_PIN2_SEL];
                ctrl_ff.pin5_sel <= wr_byte[PDM_BIT_PIN5_SEL];
            end
            if (hit_ctl) begin
                ctrl_ff.enable  <= wr_byte[PDM_BIT_ENABLE];
                ctrl_ff.div_sel <= wr_byte[PDM_DIV_SEL_MSB:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    wire [7:0] rd_idx  = s_axi_araddr_i[9:2];
    wire       rd_take = s_axi_arvalid_i && !rvalid_ff;
    wire       nxt_rvalid = rd_take || (rvalid_ff && !s_axi_rready_i);
    wire [7:0] sel_rd  = {1'b0, ctrl_ff.pin5_sel, 1'b0, ctrl_ff.pin2_sel, 4'h0};
    wire [7:0] ctl_rd  = {3'h0, ctrl_ff.enable, 1'b0, ctrl_ff.div_sel};
    wire       rd_known = (rd_idx == PDM_IDX_PORT2_SEL) || (rd_idx == PDM_IDX_DW1_HIGH)
                       || (rd_idx == PDM_IDX_DW1_LOW) || (rd_idx == PDM_IDX_DW2_HIGH)
                       || (rd_idx == PDM_IDX_DW2_LOW) || (rd_idx == PDM_IDX_CONTROL);
    wire [7:0] rd_byte =
        (rd_idx == PDM_IDX_PORT2_SEL) ? sel_rd    :
        (rd_idx == PDM_IDX_DW1_HIGH)  ? dw1_hi_ff :
        (rd_idx == PDM_IDX_DW1_LOW)   ? dw1_lo_ff :
        (rd_idx == PDM_IDX_DW2_HIGH)  ? dw2_hi_ff :
        (rd_idx == PDM_IDX_DW2_LOW)   ? dw2_lo_ff :
        (rd_idx == PDM_IDX_CONTROL)   ? ctl_rd    : 8'h00;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= PDM_RESP_OKAY;
            ardy_ff   <= 1'b1;
        end else begin
            rvalid_ff <= nxt_rvalid;
            ardy_ff   <= !nxt_rvalid;
            if (rd_take) begin
                rdata_ff <= {24'h00_0000, rd_byte};
                rresp_ff <= rd_known ? PDM_RESP_OKAY : PDM_RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // Modulator core
    // ------------------------------------------------------------------
    logic              tick;
    logic [WORD_W-1:0] phase_ff;
    logic              mod1_ff, mod2_ff;
    pdm_pins_t         pins_ff;
    wire  [WORD_W-1:0] word1 = {dw1_hi_ff, dw1_lo_ff};
    wire  [WORD_W-1:0] word2 = {dw2_hi_ff, dw2_lo_ff};
    wire  [WORD_W-1:0] nxt_phase = phase_ff + 1'b1;
    logic [WORD_W-1:0] comp_hit;

    pdm_divider #(.PRESC_W(PDM_PRESC_W)) u_div (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .run_i     (ctrl_ff.enable),
        .div_sel_i (ctrl_ff.div_sel),
        .tick_o    (tick)
    );

    // Component k fires when the low bits of the counter match the
    // pattern for k; component 15 every 2nd step, 0 every 65536th.
    genvar k;
    generate
        for (k = 0; k < WORD_W; k++) begin : g_comp
            localparam int LSB = WORD_W - 1 - k;
            if (LSB == 0) begin : g_top
                assign comp_hit[k] = phase_ff[0];
            end else begin : g_low
                assign comp_hit[k] = phase_ff[LSB] && (phase_ff[LSB-1:0] == '0);
            end
        end
    endgenerate

    // Exactly one component active per step except count 0
    wire lvl1 = |(comp_hit & word1);
    wire lvl2 = |(comp_hit & word2);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !ctrl_ff.enable) begin
            phase_ff <= '0;
            mod1_ff  <= 1'b0;
            mod2_ff  <= 1'b0;
        end else if (tick) begin
            phase_ff <= nxt_phase;
            mod1_ff  <= lvl1;
            mod2_ff  <= lvl2;
        end
    end

    // ------------------------------------------------------------------
    // Pin multiplexers
    // ------------------------------------------------------------------
    wire use2 = ctrl_ff.pin2_sel && ctrl_ff.enable;
    wire use5 = ctrl_ff.pin5_sel && ctrl_ff.enable;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pins_ff <= '{pin2_out: 1'b0, pin5_out: 1'b0, pin2_oe_n: 1'b1, pin5_oe_n: 1'b1};
        end else begin
            pins_ff.pin2_out  <= use2 ? mod1_ff : port_two_gpio_out_i[2];
            pins_ff.pin5_out  <= use5 ? mod2_ff : port_two_gpio_out_i[5];
            pins_ff.pin2_oe_n <= !port_two_direction_i[2];
            pins_ff.pin5_oe_n <= !port_two_direction_i[5];
        end
    end

    assign s_axi_awready_o = awrdy_ff;
    assign s_axi_wready_o  = wrdy_ff;
    assign s_axi_bvalid_o  = bvalid_ff;
    assign s_axi_bresp_o   = bresp_ff;
    assign s_axi_arready_o = ardy_ff;
    assign s_axi_rvalid_o  = rvalid_ff;
    assign s_axi_rdata_o   = rdata_ff;
    assign s_axi_rresp_o   = rresp_ff;
    assign pins_o          = pins_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    idle_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !ctrl_ff.enable |=> !mod1_ff && !mod2_ff && phase_ff == '0)
        else $error("modulator active while disabled");
    one_comp_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $onehot0(comp_hit))
        else $error("component pulses overlap");
    top_comp_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (ctrl_ff.enable && tick) |=> comp_hit[WORD_W-1] != $past(comp_hit[WORD_W-1]))
        else $error("component 15 not at half rate");
    zero_word_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (word1 == '0 && tick) |=> !mod1_ff)
        else $error("output high with zero density word");
    combine_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (ctrl_ff.enable && tick) |=> mod1_ff == $past(|(comp_hit & word1)))
        else $error("output not combination of selected components");
    word_two_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (ctrl_ff.enable && tick) |=> mod2_ff == $past(|(comp_hit & word2)))
        else $error("second word output wrong");
    pin2_mux_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        use2 |=> pins_o.pin2_out == $past(mod1_ff))
        else $error("pin 2 not carrying modulator");
    pin5_mux_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!use5) |=> pins_o.pin5_out == $past(port_two_gpio_out_i[5]))
        else $error("pin 5 not general purpose when unselected");
    word_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (wr_en && hit_d1h) |=> dw1_hi_ff == $past(wr_byte))
        else $error("density word one high byte not written");
    word2_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (wr_en && hit_d2l) |=> dw2_lo_ff == $past(wr_byte))
        else $error("density word two low byte not written");
    ctl_read_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rd_take && rd_idx == PDM_IDX_CONTROL) |=> rdata_ff[7:5] == 3'h0 && !rdata_ff[3])
        else $error("control reserved bits read nonzero");

    wr_cov_c: cover property (@(posedge ref_clk_i) wr_go && hit_ctl);
    rd_cov_c: cover property (@(posedge ref_clk_i) rd_take && rd_idx == PDM_IDX_DW1_LOW);
    pin2_cov_c: cover property (@(posedge ref_clk_i) use2 && mod1_ff);
    pin5_cov_c: cover property (@(posedge ref_clk_i) use5 && mod2_ff);

endmodule
`default_nettype wire

/* File: pulse_density_modulator_tb.sv */
// Self-checking bench for pdm_top: register access over AXI4-Lite and pin behaviour.
// Assumes pdm_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module pulse_density_modulator_tb;
    import pdm_pkg::*;
    // ------------------------------------------------------------------
    // Signals and tables
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX [6] = '{PDM_IDX_PORT2_SEL, PDM_IDX_DW1_HIGH, PDM_IDX_DW1_LOW,
                                       PDM_IDX_DW2_HIGH, PDM_IDX_DW2_LOW, PDM_IDX_CONTROL};
    localparam logic [7:0] MSK [6] = '{8'h50, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h17};
    logic        ref_clk_i;
    logic        reset_i;
    logic [9:0]  awaddr;
    logic [9:0]  araddr;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  gpio;
    logic [7:0]  dir;
    pdm_pins_t   pins;
    logic [33:0] rd_q[$];
    logic [1:0]  wr_q[$];
    int          err_count;
    int          checked;

    pdm_top dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .port_two_gpio_out_i(gpio), .port_two_direction_i(dir), .pins_o(pins)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("Mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: read got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: write response got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_pin(input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: pins got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_cnt(input int e, input int g);
        checked++;
        if (g != e) begin
            err_count++;
            $display("Error at %0t: count got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rsp);
        logic [31:0] r;
        logic        a_ok;
        logic        w_ok;
        r = $urandom;
        a_ok = 1'b0;
        w_ok = 1'b0;
        wr_q.push_back(rsp);
        awaddr <= {idx, 2'b00};
        wdata <= {r[31:8], d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge ref_clk_i);
            if (!a_ok && awready) begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge ref_clk_i);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [33:0] e);
        rd_q.push_back(e);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        @(posedge ref_clk_i);
        while (!arready) @(posedge ref_clk_i);
        arvalid <= 1'b0;
        @(posedge ref_clk_i);
        while (!rvalid) @(posedge ref_clk_i);
    endtask

    task automatic count(input int n, output int c2, output int c5);
        c2 = 0;
        c5 = 0;
        repeat (n) begin
            @(posedge ref_clk_i);
            c2 += int'(pins.pin2_out === 1'b1);
            c5 += int'(pins.pin5_out === 1'b1);
        end
    endtask

    task automatic run_len(output int c);
        c = 0;
        @(posedge ref_clk_i);
        while (pins.pin2_out !== 1'b0) @(posedge ref_clk_i);
        while (pins.pin2_out !== 1'b1) @(posedge ref_clk_i);
        while (pins.pin2_out === 1'b1) begin
            c++;
            @(posedge ref_clk_i);
        end
    endtask

    // Response monitor pairs each bus answer with the oldest note
    always @(posedge ref_clk_i) begin
        if (rvalid && rready && rd_q.size() > 0) cmp_rd(rd_q.pop_front(), {rresp, rdata});
        if (bvalid && bready && wr_q.size() > 0) cmp_wr(wr_q.pop_front(), bresp);
    end

    initial begin
        #200000;
        err_count++;
        stop_test();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int         c2;
        int         c5;
        int         n;
        logic [7:0] v;
        void'($urandom(32'h01B8));
        {reset_i, awvalid, wvalid, bready, arvalid, rready} = 6'h3F & 6'h20;
        {awaddr, araddr, wdata, gpio, dir} = '0;
        wstrb = 4'h1;
        err_count = 0;
        checked = 0;
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        bready <= 1'b1;
        rready <= 1'b1;
        @(posedge ref_clk_i);
        foreach (IDX[i]) rd(IDX[i], 34'h0);
        rd(8'h00, {PDM_RESP_SLVERR, 32'h0});
        wr(8'h00, 8'hFF, PDM_RESP_SLVERR);
        repeat (4) foreach (IDX[i]) begin
            v = $urandom;
            wr(IDX[i], v, PDM_RESP_OKAY);
            rd(IDX[i], {2'b00, 24'h0, v & MSK[i]});
        end
        for (int k = 0; k < 6; k++) begin
            wr(PDM_IDX_CONTROL, (k % 2) ? 8'h10 : 8'h00, PDM_RESP_OKAY);
            wr(PDM_IDX_PORT2_SEL, (k % 2) ? 8'h00 : 8'h50, PDM_RESP_OKAY);
            gpio <= $urandom;
            dir <= $urandom;
            repeat (3) @(posedge ref_clk_i);
            cmp_pin({gpio[2], gpio[5], ~dir[2], ~dir[5]}, pins);
        end
        wr(PDM_IDX_DW1_HIGH, 8'h80, PDM_RESP_OKAY);
        wr(PDM_IDX_DW1_LOW, 8'h00, PDM_RESP_OKAY);
        dir <= 8'hFF;
        wr(PDM_IDX_PORT2_SEL, 8'h50, PDM_RESP_OKAY);
        for (int d = 0; d < 8; d++) begin
            wr(PDM_IDX_CONTROL, 8'h10 | d[7:0], PDM_RESP_OKAY);
            run_len(n);
            run_len(n);
            cmp_cnt(1 << d, n);
        end
        wr(PDM_IDX_CONTROL, 8'h10, PDM_RESP_OKAY);
        wr(PDM_IDX_DW1_HIGH, 8'h12, PDM_RESP_OKAY);
        wr(PDM_IDX_DW1_LOW, 8'h28, PDM_RESP_OKAY);
        wr(PDM_IDX_DW2_HIGH, 8'h60, PDM_RESP_OKAY);
        wr(PDM_IDX_DW2_LOW, 8'h00, PDM_RESP_OKAY);
        repeat (20) @(posedge ref_clk_i);
        count(8192, c2, c5);
        cmp_cnt(581, c2);
        cmp_cnt(3072, c5);
        wr(PDM_IDX_DW1_HIGH, 8'h00, PDM_RESP_OKAY);
        wr(PDM_IDX_DW1_LOW, 8'h00, PDM_RESP_OKAY);
        wr(PDM_IDX_DW2_HIGH, 8'hE0, PDM_RESP_OKAY);
        repeat (20) @(posedge ref_clk_i);
        count(64, c2, c5);
        cmp_cnt(0, c2);
        cmp_cnt(56, c5);
        stop_test();
    end
endmodule
`default_nettype wire
